// ---- hw/snv_engine.sv ----
/*
  Command engine of the serial memory: link-side shifter on the serial clock,
  self-timed program and erase walker and power-down control on the core clock.
  Assumes the serial clock stops between frames and chip select frames every command.
*/
module snv_engine
  import snv_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  output logic cycle_busy_flag_o,
  output logic write_latch_flag_o,
  output logic sleep_mode_o,
  output logic wake_wait_o
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(DEPTH - 1);
  localparam logic [PAGE_W-1:0] OFFS_LAST = PAGE_W'(PAGE_BYTES - 1);
  localparam logic [WAKE_CNT_W-1:0] WAKE_LOAD = WAKE_CNT_W'(WAKE_DELAY_CYC);
  localparam logic [WAKE_CNT_W-1:0] WAKE_ZERO = '0;

  if (ADDR_W <= PAGE_W || ADDR_W > ADDR_FIELD_W)
    $error("ADDR_W must exceed the page offset and fit the address field");

  logic [7:0] mem [DEPTH];

  // Link side state; frame registers hold their values after select rises
  logic fresh;
  logic frame_tgl;
  logic wake_tgl;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [6:0] shift;
  logic [7:0] opcode;
  logic [ADDR_FIELD_W-1:0] addr;
  logic tx_on;
  logic [7:0] tx_byte;
  logic sdo_bit;
  logic sdo_drv;
  logic busy_s;
  logic latch_s;
  logic sleep_s;
  logic ready_s;
  logic [3:0] link_src;
  logic [3:0] link_dst;

  // Core side state
  snv_state_type state;
  logic [ADDR_W-1:0] walk;
  logic write_latch;
  logic sleep;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic cs_prev;
  logic wake_prev;
  logic frame_seen;
  logic [1:0] core_dst;
  logic cs_s;
  logic wake_s;

  logic [2:0] cur_bit;
  logic [2:0] cur_byte;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [ADDR_FIELD_W-1:0] addr_in;
  logic [ADDR_W-1:0] rd_ptr;
  logic [7:0] status_byte;
  logic read_go;
  logic status_go;
  logic core_ready;

  snv_pbuf_if pb ();

  snv_page_buf page_buf (
    .clk_i(spi_sck_i),
    .pb(pb.store)
  );

  assign link_src = {core_ready, sleep, write_latch, cycle_busy_flag_o};
  assign {ready_s, sleep_s, latch_s, busy_s} = link_dst;

  // Link stages run free; they refill within four edges, long before a byte ends
  snv_sync #(
    .WIDTH(4),
    .INIT(4'h0)
  ) link_sync (
    .clk_i(spi_sck_i),
    .rst_n_i(1'b1),
    .d_i(link_src),
    .q_o(link_dst)
  );

  snv_sync #(
    .WIDTH(2),
    .INIT(2'h1)
  ) core_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({wake_tgl, spi_cs_n_i}),
    .q_o(core_dst)
  );

  assign {wake_s, cs_s} = core_dst;

  assign cur_bit = fresh ? 3'h0 : bit_cnt;
  assign cur_byte = fresh ? BYTE_OPCODE : byte_cnt;
  assign rx_byte = {shift, spi_sdi_i};
  assign byte_done = (cur_bit == BIT_LAST);
  assign addr_in = {addr[ADDR_FIELD_W-1:8], rx_byte};
  assign rd_ptr = (cur_byte == BYTE_ADDR_LO) ? addr_in[ADDR_W-1:0] : addr[ADDR_W-1:0];

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[BUSY_BIT] = busy_s;
    status_byte[LATCH_BIT] = latch_s;
  end

  // Reads need the engine idle and awake; status needs only awake
  assign read_go = byte_done & ready_s &
    (((opcode == READ_CMD) & (cur_byte >= BYTE_ADDR_LO)) |
     ((opcode == FAST_READ_CMD) & (cur_byte >= BYTE_DUMMY)));
  assign status_go = byte_done & ~sleep_s &
    ((cur_byte == BYTE_OPCODE) ? (rx_byte == STATUS_READ_CMD) : (opcode == STATUS_READ_CMD));

  assign pb.clear = byte_done & ready_s & (cur_byte == BYTE_OPCODE) & (rx_byte == WRITE_CMD);
  assign pb.wr_en = byte_done & ready_s & (opcode == WRITE_CMD) & (cur_byte >= BYTE_DUMMY);
  assign pb.wr_addr = addr[PAGE_W-1:0];
  assign pb.wr_data = rx_byte;

  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i)
  begin
    if (spi_cs_n_i)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // Toggles survive select, so only the core reset may clear them
  always_ff @(posedge spi_sck_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frame_tgl <= 1'b0;
      wake_tgl <= 1'b0;
    end
    else
    begin
      if (fresh)
        frame_tgl <= ~frame_tgl;
      if (byte_done && cur_byte == BYTE_OPCODE && rx_byte == WAKE_CMD && sleep_s)
        wake_tgl <= ~wake_tgl;
    end
  end

  always_ff @(posedge spi_sck_i)
  begin
    bit_cnt <= cur_bit + 3'h1;
    shift <= rx_byte[6:0];
    if (byte_done && cur_byte != BYTE_CNT_MAX)
      byte_cnt <= cur_byte + 3'h1;
    else
      byte_cnt <= cur_byte;
    if (byte_done && cur_byte == BYTE_OPCODE)
      opcode <= rx_byte;
    if (byte_done && cur_byte == BYTE_ADDR_HI)
      addr[ADDR_FIELD_W-1:8] <= rx_byte;
    if (byte_done && cur_byte == BYTE_ADDR_LO)
      addr[7:0] <= rx_byte;
    if (read_go)
      addr[ADDR_W-1:0] <= rd_ptr + 1'b1;
    else if (pb.wr_en)
      addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1;
  end

  always_ff @(posedge spi_sck_i)
  begin
    if (fresh)
      tx_on <= 1'b0;
    else if (byte_done)
      tx_on <= read_go | status_go;
    if (read_go)
      tx_byte <= mem[rd_ptr];
    else if (status_go)
      tx_byte <= status_byte;
  end

  // Falling edge launch gives the host a full half period of setup
  always_ff @(negedge spi_sck_i or posedge spi_cs_n_i)
  begin
    if (spi_cs_n_i)
    begin
      sdo_bit <= 1'b0;
      sdo_drv <= 1'b0;
    end
    else
    begin
      sdo_bit <= tx_byte[~bit_cnt];
      sdo_drv <= tx_on;
    end
  end

  assign spi_sdo_o = sdo_bit;
  assign spi_sdo_oe_o = sdo_drv & ~spi_cs_n_i;

  // Core side: frame summary is read only once select is high and the clock stopped
  logic cs_rise;
  logic wake_evt;
  logic new_frame;
  logic accept;
  logic op_prog;
  logic op_page;
  logic op_chip;
  logic op_sleep;
  logic walk_done;
  logic cycle_end;
  logic [ADDR_W-1:0] page_addr;
  logic [ADDR_W-PAGE_W-1:0] page_base; // Status reads mid-cycle rewrite the frame address

  assign cs_rise = cs_s & ~cs_prev;
  assign wake_evt = wake_s ^ wake_prev;
  assign new_frame = cs_rise & (frame_tgl != frame_seen) & (bit_cnt == 3'h0);
  assign accept = new_frame & (state == ST_IDLE) & ~sleep & (wake_cnt == WAKE_ZERO);
  assign op_prog = accept & write_latch & (opcode == WRITE_CMD) &
    (byte_cnt >= WRITE_MIN_BYTES);
  assign op_page = accept & write_latch & (opcode == PAGE_ERASE_OPCODE) &
    (byte_cnt >= ERASE_MIN_BYTES);
  assign op_chip = accept & write_latch &
    ((opcode == CHIP_ERASE_OPCODE) | (opcode == CHIP_ERASE_ALT_OPCODE));
  assign op_sleep = accept & (opcode == SLEEP_CMD);
  assign walk_done = (state == ST_CHIP_ERASE) ? (walk == ADDR_LAST) :
    (walk[PAGE_W-1:0] == OFFS_LAST);
  assign cycle_end = (state != ST_IDLE) & walk_done;
  assign page_addr = {page_base, walk[PAGE_W-1:0]};
  assign pb.rd_addr = walk[PAGE_W-1:0];
  assign core_ready = (state == ST_IDLE) & ~sleep & (wake_cnt == WAKE_ZERO);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cs_prev <= 1'b1;
      wake_prev <= 1'b0;
      frame_seen <= 1'b0;
    end
    else
    begin
      cs_prev <= cs_s;
      wake_prev <= wake_s;
      if (cs_rise)
        frame_seen <= frame_tgl;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      walk <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          walk <= '0;
          if (op_prog || op_page)
            page_base <= addr[ADDR_W-1:PAGE_W];
          if (op_prog)
            state <= ST_PROG;
          else if (op_page)
            state <= ST_PAGE_ERASE;
          else if (op_chip)
            state <= ST_CHIP_ERASE;
        end
        ST_PROG, ST_PAGE_ERASE, ST_CHIP_ERASE:
        begin
          walk <= walk + 1'b1;
          if (walk_done)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Array has no reset: it is the stored content
  always_ff @(posedge ref_clk_i)
  begin
    case (state)
      ST_PROG:
        if (pb.rd_valid)
          mem[page_addr] <= pb.rd_data;
      ST_PAGE_ERASE:
        mem[page_addr] <= ERASED_BYTE;
      ST_CHIP_ERASE:
        mem[walk] <= ERASED_BYTE;
      default:
        ;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      write_latch <= 1'b0;
    else if (cycle_end || op_sleep || (accept && opcode == CLEAR_WRITE_LATCH_CMD))
      write_latch <= 1'b0;
    else if (accept && opcode == SET_WRITE_LATCH_CMD)
      write_latch <= 1'b1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sleep <= 1'b0;
      wake_cnt <= WAKE_ZERO;
    end
    else if (sleep && wake_evt)
    begin
      sleep <= 1'b0;
      wake_cnt <= WAKE_LOAD;
    end
    else
    begin
      if (op_sleep)
        sleep <= 1'b1;
      if (wake_cnt != WAKE_ZERO)
        wake_cnt <= wake_cnt - 1'b1;
    end
  end

  assign cycle_busy_flag_o = (state != ST_IDLE);
  assign write_latch_flag_o = write_latch;
  assign sleep_mode_o = sleep;
  assign wake_wait_o = (wake_cnt != WAKE_ZERO);

  prog_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_prog |=> state == ST_PROG && cycle_busy_flag_o)
    else $error("write frame did not start a program cycle");

  no_latch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    accept && !write_latch && opcode == WRITE_CMD |=> state == ST_IDLE)
    else $error("write without latch was not ignored");

  busy_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state != ST_IDLE && !walk_done |=> $stable(write_latch) && $stable(sleep))
    else $error("command obeyed during internal cycle");

  latch_end_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state == ST_PROG && walk_done |=> !write_latch && state == ST_IDLE)
    else $error("latch not cleared at program end");

  page_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(state == ST_PAGE_ERASE) |-> ##31 (state == ST_PAGE_ERASE && walk_done)
      ##1 state == ST_IDLE)
    else $error("page erase did not cover exactly one page");

  sleep_enter_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    op_sleep |=> sleep && !write_latch)
    else $error("sleep opcode did not enter power-down");

  sleep_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sleep && !wake_evt |=> sleep && state == ST_IDLE)
    else $error("power-down left without wake");

  wake_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sleep && wake_evt |=> !sleep && wake_cnt == WAKE_LOAD ##1 !core_ready)
    else $error("wake delay not started");

  stat_pad_a: assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i)
    tx_on && opcode == STATUS_READ_CMD |-> tx_byte[7:2] == 6'h00)
    else $error("status reserved bits not zero");

  page_wrap_a: assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i)
    pb.wr_en |=> addr[PAGE_W-1:0] == PAGE_W'($past(addr[PAGE_W-1:0]) + 1'b1)
      && addr[ADDR_FIELD_W-1:PAGE_W] == $past(addr[ADDR_FIELD_W-1:PAGE_W]))
    else $error("write pointer left its page");
endmodule : snv_engine

// ---- hw/snv_page_buf.sv ----
/*
  Page buffer of one page with a per-byte valid mask.
  Assumes clear and write never coincide and reads happen between frames.
*/
module snv_page_buf
  import snv_pkg::*;
(
  input wire logic clk_i,
  snv_pbuf_if.store pb
);
  logic [7:0] data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid;
  always_ff @(posedge clk_i)
  begin
    if (pb.clear)
      valid <= '0;
    else if (pb.wr_en)
      valid[pb.wr_addr] <= 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (pb.wr_en)
      data[pb.wr_addr] <= pb.wr_data;
  end
  assign pb.rd_data = data[pb.rd_addr];
  assign pb.rd_valid = valid[pb.rd_addr];
endmodule : snv_page_buf

// ---- hw/snv_pbuf_if.sv ----
/*
  Page buffer port bundle between the link side and the program walker.
  Assumes the filler runs on the serial clock and the drainer reads only while
  select is high, so the stored bytes stand still.
*/
interface snv_pbuf_if;
  import snv_pkg::*;
  logic clear;
  logic wr_en;
  logic [PAGE_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [PAGE_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;
  modport fill (output clear, wr_en, wr_addr, wr_data);
  modport drain (output rd_addr, input rd_data, rd_valid);
  modport store (input clear, wr_en, wr_addr, wr_data, rd_addr, output rd_data, rd_valid);
endinterface : snv_pbuf_if

// ---- hw/snv_pkg.sv ----
/*
  Constants, opcodes and types shared by the serial memory command engine.
  Assumes a host SPI master that drives chip select, serial clock and serial input.
*/
// Summary of operation
// - Fast read: opcode, two address bytes, one dummy byte, then data MSB first.
// - Only the low twelve address bits are decoded; host sends upper bits as zero.
// - Reads continue while select stays low, address wrapping from top to zero.
// - Select rising at the end of a write starts the self-timed write cycle.
// - During an internal cycle every command except status read is ignored.
// - Status bit 0 is one while a write or erase cycle runs, else zero.
// - Each write data byte advances only the five low address bits.
// - More than 32 write bytes: the last 32 within the page are kept.
// - Fewer than 32 write bytes leave the other bytes of the page unchanged.
// - The write latch clears when a program cycle completes.
// - A write without the latch set is ignored; select rising returns to standby.
// - Page erase sets every bit of the addressed 32-byte page to one.
// - Page erase is opcode plus two address bytes; page offset bits ignored.
// - Select rising after page erase address starts a timed erase, busy shown.
// - Two opcodes start the same chip erase, no address, all bits to one.
// - Select rising after chip erase starts it, busy shown, latch required.
// - Select rising after the sleep opcode enters power-down.
// - In power-down only the wake command is obeyed and leaves the mode.
// - Wake acts at the eighth rising clock; reads and writes wait 75 us.
// - All bytes travel MSB first from the first rising clock after select falls.
// - A frame not ending on a byte boundary leaves the write latch alone.
// - Status holds busy in bit 0, latch in bit 1, other bits zero.
package snv_pkg;
  localparam int ADDR_W_DEF = 12;
  localparam int ADDR_FIELD_W = 16;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] WRITE_CMD = 8'h02;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0B;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] PAGE_ERASE_OPCODE = 8'h42;
  localparam logic [7:0] CHIP_ERASE_OPCODE = 8'h60;
  localparam logic [7:0] CHIP_ERASE_ALT_OPCODE = 8'hC7;
  localparam logic [7:0] SLEEP_CMD = 8'hB9;
  localparam logic [7:0] WAKE_CMD = 8'hAB;
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BYTE_OPCODE = 3'h0;
  localparam logic [2:0] BYTE_ADDR_HI = 3'h1;
  localparam logic [2:0] BYTE_ADDR_LO = 3'h2;
  localparam logic [2:0] BYTE_DUMMY = 3'h3;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
  localparam logic [2:0] WRITE_MIN_BYTES = 3'h4;
  localparam logic [2:0] ERASE_MIN_BYTES = 3'h3;
  localparam int CLK_FREQ_MHZ = 10;
  localparam int WAKE_DELAY_US = 75;
  localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_FREQ_MHZ;
  localparam int WAKE_CNT_W = $clog2(WAKE_DELAY_CYC + 1);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PROG = 4'b0010,
    ST_PAGE_ERASE = 4'b0100,
    ST_CHIP_ERASE = 4'b1000
  } snv_state_type;
endpackage : snv_pkg

// ---- hw/snv_sync.sv ----
/*
  Three-stage level synchroniser; a bit changes once stages two and three agree.
  Assumes each bit is an independent slow level.
*/
module snv_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q_o <= INIT;
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= (s2 & s3) | (q_o & (s2 ^ s3));
    end
  end
endmodule : snv_sync

// ---- tb/snv_host.sv ----
/*
  Host SPI master model for the serial memory engine bench, clock idle low.
  Assumes the bench fills tx_buf before each frame and leaves cs high between frames.
*/
module snv_host (
  output logic sck_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_buf [64];
  logic [7:0] rx_buf [64];
  logic oe_seen;
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    oe_seen = 1'b0;
  end
  // Clock stands still outside frames; sdi flips after release so no stale level lingers
  task automatic frame(input int nbytes, input int xbits);
    oe_seen = 1'b0;
    #7 cs_n_o = 1'b0;
    for (int i = 0; i < nbytes * 8 + xbits; i++)
    begin
      sdi_o = tx_buf[i / 8][7 - i % 8];
      #16 sck_o = 1'b1;
      oe_seen = oe_seen | sdo_oe_i;
      // Undriven line reads as the inverse of our own bit, never a lucky match
      rx_buf[i / 8][7 - i % 8] = sdo_oe_i ? sdo_i : ~sdi_o;
      #16 sck_o = 1'b0;
    end
    #8 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask : frame
endmodule : snv_host

// ---- tb/tb_snv_engine.sv ----
/*
  Self-checking bench for the serial memory command engine.
  Assumes snv_host as SPI master on a 32 ns serial clock; core clock 100 ns.
*/
module tb_snv_engine
  import snv_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic rst_n;
  logic sck, cs_n, sdi, sdo, sdo_oe;
  logic busy, latch, sleep, wake_wait;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] exp_buf [40];

  snv_engine #(.ADDR_W(12)) DUT (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .cycle_busy_flag_o(busy),
    .write_latch_flag_o(latch), .sleep_mode_o(sleep), .wake_wait_o(wake_wait));
  snv_host host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Two chip erases dominate the run; this ceiling leaves ample margin
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Sample one step after the edge so the design's updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic send(input int n, input int xbits);
    host.frame(n, xbits);
    cyc(8);
  endtask : send

  task automatic cmd(input logic [7:0] op);
    host.tx_buf[0] = op;
    send(1, 0);
  endtask : cmd

  task automatic hdr(input logic [7:0] op, input logic [11:0] addr);
    host.tx_buf[0] = op;
    host.tx_buf[1] = {4'h0, addr[11:8]};
    host.tx_buf[2] = addr[7:0];
    host.tx_buf[3] = 8'h5A;
  endtask : hdr

  task automatic status(input logic [7:0] exp);
    hdr(STATUS_READ_CMD, 12'h000);
    send(3, 0);
    chk(host.rx_buf[1], exp);
    chk(host.rx_buf[2], exp);
  endtask : status

  task automatic rd(input logic [11:0] addr, input int n);
    hdr(FAST_READ_CMD, addr);
    send(n + 4, 0);
    for (int i = 0; i < n; i++)
      chk(host.rx_buf[i + 4], exp_buf[i]);
    chk(sdo_oe, 1'b0);
  endtask : rd

  task automatic wr(input logic [11:0] addr, input int n, input logic [7:0] base);
    hdr(WRITE_CMD, addr);
    for (int i = 0; i < n; i++)
      host.tx_buf[i + 3] = 8'(base + i);
    send(n + 3, 0);
  endtask : wr

  task automatic run_cycle();
    int n;
    n = 0;
    chk(busy, 1'b1);
    while (busy === 1'b1 && n < 5000)
    begin
      cyc(1);
      n++;
    end
    chk(busy, 1'b0);
    chk(latch, 1'b0);
  endtask : run_cycle

  task automatic t_erase(input logic [7:0] op);
    cmd(SET_WRITE_LATCH_CMD);
    chk(latch, 1'b1);
    cmd(op);
    status(8'h03);
    cmd(CLEAR_WRITE_LATCH_CMD);
    chk(latch, 1'b1);
    hdr(FAST_READ_CMD, 12'h000);
    send(5, 0);
    chk(host.oe_seen, 1'b0);
    run_cycle();
    status(8'h00);
  endtask : t_erase

  task automatic t_write_wrap();
    cmd(SET_WRITE_LATCH_CMD);
    wr(12'h01E, 3, 8'hA1);
    run_cycle();
    exp_buf = '{default: ERASED_BYTE};
    exp_buf[1] = 8'hA3;
    rd(12'hFFF, 3);
    exp_buf[1] = 8'hA1;
    exp_buf[2] = 8'hA2;
    rd(12'h01D, 4);
  endtask : t_write_wrap

  task automatic t_write_long();
    cmd(SET_WRITE_LATCH_CMD);
    wr(12'h040, 34, 8'h00);
    status(8'h03);
    run_cycle();
    for (int k = 0; k < 32; k++)
      exp_buf[k] = (k < 2) ? 8'(k + 32) : 8'(k);
    rd(12'h040, 32);
  endtask : t_write_long

  task automatic t_no_latch();
    wr(12'h041, 1, 8'h55);
    chk(busy, 1'b0);
    exp_buf[0] = 8'h21;
    rd(12'h041, 1);
  endtask : t_no_latch

  task automatic t_page_erase();
    cmd(SET_WRITE_LATCH_CMD);
    hdr(PAGE_ERASE_OPCODE, 12'h053);
    send(3, 0);
    run_cycle();
    exp_buf = '{default: ERASED_BYTE};
    rd(12'h03F, 3);
    exp_buf[0] = 8'hA1;
    rd(12'h01E, 1);
  endtask : t_page_erase

  task automatic t_abort();
    cmd(SET_WRITE_LATCH_CMD);
    host.tx_buf[0] = CLEAR_WRITE_LATCH_CMD;
    host.tx_buf[1] = 8'h00;
    send(1, 3);
    chk(latch, 1'b1);
    cmd(CLEAR_WRITE_LATCH_CMD);
    chk(latch, 1'b0);
  endtask : t_abort

  task automatic t_sleep();
    int n;
    cmd(SET_WRITE_LATCH_CMD);
    cmd(SLEEP_CMD);
    chk(sleep, 1'b1);
    chk(latch, 1'b0);
    cmd(SET_WRITE_LATCH_CMD);
    chk(latch, 1'b0);
    hdr(STATUS_READ_CMD, 12'h000);
    send(2, 0);
    chk(host.oe_seen, 1'b0);
    host.tx_buf[0] = WAKE_CMD;
    host.frame(1, 0);
    n = 0;
    while (wake_wait !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (wake_wait === 1'b1 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    chk(16'(n), 16'(WAKE_DELAY_CYC));
    chk(sleep, 1'b0);
    cmd(SET_WRITE_LATCH_CMD);
    chk(latch, 1'b1);
  endtask : t_sleep

  initial
  begin
    rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(5);
    chk({busy, latch, sleep, wake_wait}, 4'h0);
    t_erase(CHIP_ERASE_OPCODE);
    exp_buf = '{default: ERASED_BYTE};
    rd(12'hFFE, 4);
    t_write_wrap();
    t_write_long();
    t_no_latch();
    t_page_erase();
    t_abort();
    t_sleep();
    t_erase(CHIP_ERASE_ALT_OPCODE);
    hdr(READ_CMD, 12'h040);
    send(4, 0);
    chk(host.rx_buf[3], ERASED_BYTE);
    end_sim();
  end
endmodule : tb_snv_engine
